// ===== hw/ccmp_consts.svh
// Purpose: named offsets, fields, codes and timing figures of the compare block
// Assumes: included by bare name from the design files
// Notes: byte addresses on a 32-bit apb bus, one aligned word per register
`ifndef CCMP_CONSTS_SVH
`define CCMP_CONSTS_SVH

// register byte offsets
`define CCMP_OFS_CTRL      12'h000
`define CCMP_OFS_HYST      12'h004
`define CCMP_OFS_PULSE     12'h008
`define CCMP_OFS_VAL1      12'h00c
`define CCMP_OFS_VAL2      12'h010
`define CCMP_OFS_ACK       12'h014
`define CCMP_OFS_STAT      12'h018

// control register fields
`define CCMP_CTRL_FUNC1    2:0
`define CCMP_CTRL_FUNC2    5:3
`define CCMP_CTRL_EN1      6
`define CCMP_CTRL_EN2      7
`define CCMP_CTRL_FORCE1   8
`define CCMP_CTRL_FORCE2   9
`define CCMP_CTRL_MDIR     11:10
`define CCMP_CTRL_ISO      12
`define CCMP_CTRL_RST      32'h0000_0000

// acknowledge register fields
`define CCMP_ACK_FLAG1     0
`define CCMP_ACK_FLAG2     1
`define CCMP_ACK_LOADERR   2

// output function codes
`define CCMP_FN_OUTPUT     3'h0
`define CCMP_FN_GE         3'h1
`define CCMP_FN_LE         3'h2
`define CCMP_FN_PULSE      3'h3
`define CCMP_FN_WINDOW     3'h4

// main count direction codes
`define CCMP_DIR_NONE      2'h0
`define CCMP_DIR_UP        2'h1
`define CCMP_DIR_DOWN      2'h2

// comparison value limits
`define CCMP_VAL_MAX       32'sh7fff_ffff
`define CCMP_VAL_MIN_DOWN  32'sh0000_0001

// pulse step timing
`define CCMP_CLK_HZ        50000000
`define CCMP_PULSE_STEP_MS 2
`define CCMP_STEP_CYC      ((`CCMP_CLK_HZ / 1000) * `CCMP_PULSE_STEP_MS)

`endif

// ===== hw/ccmp_outputs.sv
// Purpose: comparator driven real and virtual outputs of a 32-bit counter, apb slave
// Assumes: count, count_step and count_up come from the counting core on clk_sys
// Notes: one wait state on every apb access; channel 0 is the real output
//
// Overview of operation
// RL1: window mode: on inside v2..v1 if v2<=v1, else on outside v1..v2.
// RL2: window switches only after both values loaded, then output one enabled.
// RL3: window result in comparator one flag; ack clears only when condition gone.
// RL4: window mode uses no hysteresis.
// RL5: master must not force output one in window mode.
// RL6: real output switches at once; virtual output sampled at input sampling instant.
// RL7: window needs hysteresis zero and virtual output plain; otherwise parameter error.
// RL8: hysteresis width 0 to 255 counts, zero disables it.
// RL9: hysteresis range works across counter wraparound.
// RL10: ge/le: condition met activates hysteresis, freezes result until range left.
// RL11: direction reversal at comparison value with active hysteresis resets output.
// RL12: pulse, duration zero: result held, cleared when hysteresis range left.
// RL13: pulse, nonzero duration: pulse on activation, another on opposite-direction exit.
// RL14: force rising edge sets output while comparators keep working.
// RL15: pulse mode force edge gives one pulse; duration zero ignores force.
// RL16: force falling edge resets the output.
// RL17: comparators may change outputs, but never clear a forced output.
// RL18: loading comparison values leaves the running count untouched.
// RL19: master keeps comparison values within range for the main direction.
// RL20: function change meeting condition sets output after next count pulse only; window mode sets output once armed, without a count pulse.
// RL21: hysteresis width change applies next time the comparison value is reached.
// RL22: pulse duration change applies from the next pulse.
// RL23: control and feedback words transfer whole, never split.
// RL24: pulse duration 0 to 510 ms in 2 ms steps, error below 2 ms.
// RL25: pulse triggers from either direction, or main direction only.
// RL26: signed 32-bit compare, reevaluated every cycle.
`include "ccmp_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module ccmp_outputs #(
  parameter int unsigned PULSE_STEP_CYC = `CCMP_STEP_CYC  // cycles per 2 ms step
) (
  input  wire logic        clk_sys,         // system clock, 50 mhz
  input  wire logic        rst,             // synchronous reset, active high
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb enable
  input  wire logic        pwrite,          // apb direction
  input  wire logic [11:0] paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  output logic             pready,          // apb ready
  output logic      [31:0] prdata,          // apb read data
  output logic             pslverr,         // apb error, unmapped address
  input  wire logic [31:0] count,           // signed count from the core
  input  wire logic        count_step,      // pulse: count just changed
  input  wire logic        count_up,        // direction of that change
  input  wire logic        sample_strobe,   // pulse: input sampling instant
  output logic             real_output,     // real digital output
  output logic             virtual_output   // virtual output as sampled
);

  // apb handshake and decode
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  wire         acc      = psel & penable;
  wire         wr_fire  = acc & pwrite & pready_r;
  wire         hit_ctrl = (paddr == `CCMP_OFS_CTRL);
  wire         hit_hyst = (paddr == `CCMP_OFS_HYST);
  wire         hit_puls = (paddr == `CCMP_OFS_PULSE);
  wire         hit_val1 = (paddr == `CCMP_OFS_VAL1);
  wire         hit_val2 = (paddr == `CCMP_OFS_VAL2);
  wire         hit_ack  = (paddr == `CCMP_OFS_ACK);
  wire         hit_stat = (paddr == `CCMP_OFS_STAT);
  wire         mapped   = hit_ctrl | hit_hyst | hit_puls | hit_val1 | hit_val2 | hit_ack
                          | hit_stat;

  // software state
  ccmp_pkg::ccmp_word_t ctrl_r;
  logic [7:0]           hyst_r;
  logic [7:0]           plen_r;
  logic signed [31:0]   val1_r;
  logic signed [31:0]   val2_r;
  logic                 loaded1_r;
  logic                 loaded2_r;
  logic                 armed_r;
  logic                 load_err_r;
  logic                 par_err_r;
  logic                 vsmp_r;
  logic                 en1_d_r;
  logic signed [31:0]   cnt_d_r;

  ccmp_pkg::ccmp_func_t func1;
  ccmp_pkg::ccmp_func_t func2;
  ccmp_pkg::ccmp_dir_t  mdir;
  assign func1 = ctrl_r[`CCMP_CTRL_FUNC1];
  assign func2 = ctrl_r[`CCMP_CTRL_FUNC2];
  assign mdir  = ctrl_r[`CCMP_CTRL_MDIR];
  wire   iso   = ctrl_r[`CCMP_CTRL_ISO];
  wire   ack_w = wr_fire & hit_ack;

  // load range check per main direction
  wire signed [31:0] wval    = pwdata;
  wire               val_bad = ((mdir == `CCMP_DIR_UP) && (wval == `CCMP_VAL_MAX))
                               || ((mdir == `CCMP_DIR_DOWN) && (wval < `CCMP_VAL_MIN_DOWN));
  wire               ld_try  = wr_fire & (hit_val1 | hit_val2);

  // RL7 window dependencies
  wire par_err_nxt = ((func1 == `CCMP_FN_WINDOW) && ((hyst_r != 8'h00)
                     || (func2 != `CCMP_FN_OUTPUT))) || (func1 > `CCMP_FN_WINDOW)
                     || (func2 > `CCMP_FN_PULSE);

  // RL24 pulse length in 2 ms steps
  wire [31:0] plen_cyc = 32'({24'h0, plen_r} * PULSE_STEP_CYC);

  // channel results read back by the bus and the ports
  logic [1:0] out_w;
  logic [1:0] flag_w;
  logic [1:0] hact_w;

  // RL23 whole-word register writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_r <= `CCMP_CTRL_RST;
      hyst_r <= 8'h00;
      plen_r <= 8'h00;
    end else if (wr_fire) begin
      if (hit_ctrl) ctrl_r <= pwdata;
      // RL8 hysteresis width 0 to 255
      if (hit_hyst) hyst_r <= pwdata[7:0];
      if (hit_puls) plen_r <= pwdata[7:0];
    end
  end

  // RL18 values load apart from the count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      val1_r    <= 32'sh0;
      val2_r    <= 32'sh0;
      loaded1_r <= 1'b0;
      loaded2_r <= 1'b0;
    end else if (ld_try && !val_bad) begin
      if (hit_val1) val1_r <= wval;
      if (hit_val1) loaded1_r <= 1'b1;
      if (hit_val2) val2_r <= wval;
      if (hit_val2) loaded2_r <= 1'b1;
    end
  end

  // error flags, set wins over ack
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      load_err_r <= 1'b0;
      par_err_r  <= 1'b0;
    end else begin
      load_err_r <= (ld_try & val_bad) | (load_err_r & ~(ack_w & pwdata[`CCMP_ACK_LOADERR]));
      par_err_r  <= par_err_nxt;
    end
  end

  // RL2 arm window on enable after both loads
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      armed_r <= 1'b0;
      en1_d_r <= 1'b0;
    end else begin
      en1_d_r <= ctrl_r[`CCMP_CTRL_EN1];
      if (!ctrl_r[`CCMP_CTRL_EN1] || (func1 != `CCMP_FN_WINDOW))
        armed_r <= 1'b0;
      else if (!en1_d_r && loaded1_r && loaded2_r)
        armed_r <= 1'b1;
    end
  end

  // RL6 virtual output sampled at strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vsmp_r  <= 1'b0;
      cnt_d_r <= 32'sh0;
    end else begin
      cnt_d_r <= count;
      if (!iso || sample_strobe) vsmp_r <= out_w[1];
    end
  end

  // per-channel comparator, hysteresis and pulse logic
  for (genvar c = 0; c < 2; c++) begin : ch_g
    logic               out_r, res_r, hact_r, hdir_r, frc_r, fdr_r, wait_r, flag_r;
    logic [7:0]         hw_r;
    logic signed [31:0] base_r;
    logic [31:0]        tim_r;
    ccmp_pkg::ccmp_func_t fprev_r;
    logic               res_n, hact_n, hdir_n, frc_n, wait_n, out_n;
    logic [7:0]         hw_n;
    logic signed [31:0] base_n;
    logic [31:0]        tim_n;

    wire ccmp_pkg::ccmp_func_t fn = (c == 0) ? func1 : func2;
    wire               en    = ctrl_r[`CCMP_CTRL_EN1 + c];
    wire               fbit  = ctrl_r[`CCMP_CTRL_FORCE1 + c];
    wire signed [31:0] cv    = (c == 0) ? val1_r : val2_r;
    wire signed [31:0] cnt   = count;
    // RL9 modular distance survives wraparound
    wire [31:0]        dif   = 32'(cnt - base_r);
    wire [31:0]        adif  = dif[31] ? 32'(-dif) : dif;
    wire               outr  = adif > {24'h0, hw_r};
    // RL26 signed compares every cycle
    wire               c_ge  = cnt >= cv;
    wire               c_le  = cnt <= cv;
    // RL1 window decode
    wire               w_in  = (val2_r <= val1_r) ? ((cnt >= val2_r) && (cnt <= val1_r))
                                                  : ((cnt < val1_r) || (cnt > val2_r));
    // RL25 direction filter
    wire               dokay = (mdir == `CCMP_DIR_NONE) || ((mdir == `CCMP_DIR_UP) && count_up)
                               || ((mdir == `CCMP_DIR_DOWN) && !count_up);
    wire               hit   = count_step && (cnt == cv) && dokay;
    wire               cond  = (fn == `CCMP_FN_GE) ? c_ge : c_le;
    wire               f_ris = fbit & ~fdr_r;
    wire               f_fal = ~fbit & fdr_r;
    wire               is_win = (c == 0) && (fn == `CCMP_FN_WINDOW);
    wire               is_pul = (fn == `CCMP_FN_PULSE);
    wire               fchg  = (fn != fprev_r);
    wire               ack   = ack_w & pwdata[`CCMP_ACK_FLAG1 + c];

    // next state of one channel
    always_comb begin
      res_n  = res_r;
      hact_n = hact_r;
      hdir_n = hdir_r;
      base_n = base_r;
      hw_n   = hw_r;
      frc_n  = frc_r;
      wait_n = wait_r;
      tim_n  = (tim_r != 32'h0) ? 32'(tim_r - 32'h1) : 32'h0;
      // RL20 hold off until next count pulse
      if (fchg) wait_n = 1'b1;
      else if (count_step) wait_n = 1'b0;
      // RL10 leave hysteresis range
      if (hact_r && outr) begin
        hact_n = 1'b0;
        // RL12 clear held result on exit
        if (is_pul && (plen_r == 8'h00)) res_n = 1'b0;
        // RL13 pulse on opposite-direction exit
        if (is_pul && (plen_r != 8'h00) && (count_up != hdir_r)) tim_n = plen_cyc;
      end
      case (fn)
        `CCMP_FN_GE, `CCMP_FN_LE: begin
          if (!hact_r) begin
            res_n = wait_r ? (res_r & cond) : cond;
            // RL21 width latched at activation
            if (cond && !res_r && !wait_r && (hyst_r != 8'h00)) begin
              hact_n = 1'b1;
              base_n = cnt;
              hdir_n = count_up;
              hw_n   = hyst_r;
            end
          end else if (count_step && (cnt_d_r == cv) && (count_up != hdir_r)) begin
            // RL11 reversal on the value
            res_n = 1'b0;
          end
        end
        `CCMP_FN_PULSE: begin
          if (hit && !hact_r && !wait_r) begin
            // RL12 zero duration holds result
            if (plen_r == 8'h00) res_n = 1'b1;
            // RL22 new length from this pulse
            else tim_n = plen_cyc;
            if (hyst_r != 8'h00) begin
              hact_n = 1'b1;
              base_n = cnt;
              hdir_n = count_up;
              hw_n   = hyst_r;
            end
          end else if (!hact_r && (hyst_r == 8'h00) && (cnt != cv)) begin
            res_n = 1'b0;
          end
        end
        default: begin
          // RL4 window without hysteresis
          res_n  = is_win && armed_r && w_in;
          hact_n = 1'b0;
        end
      endcase
      // function change clears unless hysteresis holds
      if (fchg && !hact_r) res_n = 1'b0;
      // RL14 rising force edge sets
      if (f_ris && !is_win) begin
        // RL15 single pulse, none at zero length
        if (is_pul) begin
          if (plen_r != 8'h00) tim_n = plen_cyc;
        end else begin
          frc_n = 1'b1;
        end
      end
      // RL16 falling force edge resets
      if (f_fal) begin
        frc_n = 1'b0;
        tim_n = 32'h0;
        res_n = 1'b0;
      end
      // RL17 forced level outlives comparator
      out_n = en && (res_n || frc_n || (tim_n != 32'h0));
    end

    // channel registers
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        out_r   <= 1'b0;
        res_r   <= 1'b0;
        hact_r  <= 1'b0;
        hdir_r  <= 1'b0;
        base_r  <= 32'sh0;
        hw_r    <= 8'h00;
        frc_r   <= 1'b0;
        fdr_r   <= 1'b0;
        wait_r  <= 1'b0;
        tim_r   <= 32'h0;
        fprev_r <= `CCMP_FN_OUTPUT;
      end else begin
        out_r   <= out_n;
        res_r   <= res_n;
        hact_r  <= hact_n;
        hdir_r  <= hdir_n;
        base_r  <= base_n;
        hw_r    <= hw_n;
        frc_r   <= frc_n;
        fdr_r   <= fbit;
        wait_r  <= wait_n;
        tim_r   <= tim_n;
        fprev_r <= fn;
      end
    end

    // RL3 flag clears only when result gone
    always_ff @(posedge clk_sys) begin
      if (rst) flag_r <= 1'b0;
      else flag_r <= out_n | (f_ris & ~en) | (flag_r & ~(ack & ~out_n & ~res_n));
    end

    assign out_w[c]  = out_r;
    assign flag_w[c] = flag_r;
    assign hact_w[c] = hact_r;
  end

  // read mux
  wire [31:0] rd_val = hit_ctrl ? ctrl_r :
                       hit_hyst ? {24'h0, hyst_r} :
                       hit_puls ? {24'h0, plen_r} :
                       hit_val1 ? val1_r :
                       hit_val2 ? val2_r :
                       hit_stat ? {23'h0, hact_w, load_err_r, par_err_r, flag_w, vsmp_r, out_w} :
                       32'h0;

  // apb answer, one wait state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= acc & ~pready_r;
      prdata_r  <= (acc & ~pready_r & ~pwrite) ? rd_val : 32'h0;
      pslverr_r <= acc & ~pready_r & ~mapped;
    end
  end

  assign pready         = pready_r;
  assign prdata         = prdata_r;
  assign pslverr        = pslverr_r;
  assign real_output    = out_w[0];
  assign virtual_output = vsmp_r;

endmodule

`default_nettype wire

// ===== hw/ccmp_pkg.sv
// Purpose: shared types of the compare output block
// Assumes: constants come from ccmp_consts.svh
// Notes: types only
package ccmp_pkg;
  typedef logic [2:0]  ccmp_func_t;
  typedef logic [1:0]  ccmp_dir_t;
  typedef logic [31:0] ccmp_word_t;
endpackage

// ===== test/ccmp_apb_master.sv
// Purpose: bus master partner, one apb transfer per call
// Assumes: slave answers with pready
// Notes: a wait past its bound is counted in timeouts
`timescale 1ns/10ps
`default_nettype none
module ccmp_apb_master (
  input  wire logic        clk_sys,  // clock
  input  wire logic        pready,   // ready
  input  wire logic [31:0] prdata,   // read data
  input  wire logic        pslverr,  // error
  output logic             psel,     // select
  output logic             penable,  // enable
  output logic             pwrite,   // direction
  output logic      [11:0] paddr,    // address
  output logic      [31:0] pwdata    // write data
);
  int timeouts = 0;
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (pready !== 1'b1) timeouts++;  // no answer within the bound
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== test/ccmp_outputs_sva.sv
// Purpose: port assertions for the compare output block
// Assumes: bound to ccmp_outputs, apb with one wait state
// Notes: sees the top ports only
`timescale 1ns/10ps
`default_nettype none
module ccmp_outputs_chk #(
  parameter int unsigned PULSE_STEP_CYC = 10  // cycles per step
) (
  input wire logic        clk_sys,     // clock
  input wire logic        rst,         // sync reset
  input wire logic        psel,        // select
  input wire logic        penable,     // enable
  input wire logic [11:0] paddr,       // address
  input wire logic        pready,      // ready
  input wire logic [31:0] prdata,      // read data
  input wire logic        pslverr,     // error
  input wire logic        real_output  // real output
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // completed access
  wire acc = psel && penable && pready;

  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_cause_a: assert property (pready |-> psel && penable && $past(psel))
    else $error("ready without request");
  ready_lat_a: assert property ($rose(penable) && psel |=> pready)
    else $error("ready late");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_map_a: assert property (acc && paddr == 12'h100 |-> pslverr)
    else $error("unmapped not refused");
  noerr_map_a: assert property (acc && paddr == 12'h000 |-> !pslverr)
    else $error("mapped refused");
  out_reset_a: assert property ($past(rst) |-> !real_output && !pready)
    else $error("output after reset");
endmodule
bind ccmp_outputs ccmp_outputs_chk #(.PULSE_STEP_CYC(PULSE_STEP_CYC)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .real_output(real_output));
`default_nettype wire

// ===== test/tb_counter_compare_outputs.sv
// Purpose: self-checking bench of the compare output block
// Assumes: partner master drives the apb side
// Notes: pulse step shortened to 10 cycles
`include "ccmp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_counter_compare_outputs;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] count = 32'h0;
  logic        count_step = 1'b0;
  logic        count_up = 1'b1;
  logic        sample_strobe = 1'b0;
  wire         psel, penable, pwrite, pready, pslverr, real_output, virtual_output;
  wire  [11:0] paddr;
  wire  [31:0] pwdata, prdata;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          v1, v2, c, n;
  logic [31:0] rd;
  logic        er;

  // 50 mhz clock
  always #10 clk_sys = ~clk_sys;

  ccmp_apb_master u_mst (.clk_sys(clk_sys), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  ccmp_outputs #(.PULSE_STEP_CYC(10)) DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .count(count),
    .count_step(count_step), .count_up(count_up), .sample_strobe(sample_strobe),
    .real_output(real_output), .virtual_output(virtual_output));

  task automatic check(input logic [31:0] g, input logic [31:0] x, input string m);
    cmp_count++;
    if (g !== x) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  // one bus transfer, a timed-out wait ends the run
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    u_mst.xfer(w, a, d, rd, er);
    if (u_mst.timeouts != 0) give_verdict();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdb(input logic [11:0] a, input int b, input logic x);
    bus(1'b0, a, 32'h0);
    check({31'h0, rd[b]}, {31'h0, x}, "status bit");
  endtask
  // one count change, output compared one edge later
  task automatic step(input int k, input logic x);
    @(posedge clk_sys);
    count_up <= k > $signed(count);
    count <= k;
    count_step <= 1'b1;
    @(posedge clk_sys);
    count_step <= 1'b0;
    #1 check({31'h0, real_output}, {31'h0, x}, "real output");
  endtask
  // length of the next output pulse in cycles
  task automatic plen(output int p);
    int k;
    k = 0;
    p = 0;
    while (real_output !== 1'b1 && k < 5) begin
      @(posedge clk_sys);
      #1 k++;
    end
    while (real_output === 1'b1 && p < 100) begin
      @(posedge clk_sys);
      #1 p++;
    end
  endtask
  function automatic logic win(input int k, input int a, input int b);
    return (b <= a) ? (k >= b && k <= a) : (k < a || k > b);
  endfunction
  task automatic give_verdict();
    num_errors += u_mst.timeouts;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    void'($urandom(78227));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, 12'h100, 32'h0);
    check({31'h0, er}, 32'h1, "unmapped");
    rdb(`CCMP_OFS_STAT, 0, 1'b0);
    // greater-or-equal, no hysteresis, up then down
    wr(`CCMP_OFS_VAL1, 32'h5);
    wr(`CCMP_OFS_CTRL, 32'h41);
    for (c = 0; c < 10; c++) step(c, c >= 5);
    for (c = 8; c >= 0; c--) step(c, c >= 5);
    // reversal on the value with hysteresis active
    wr(`CCMP_OFS_HYST, 32'h3);
    for (c = 1; c < 6; c++) step(c, c >= 5);
    step(4, 1'b0);
    wr(`CCMP_OFS_HYST, 32'h0);
    step(0, 1'b0);
    // force edges override the comparator
    wr(`CCMP_OFS_CTRL, 32'h141);
    step(1, 1'b1);
    step(2, 1'b1);
    wr(`CCMP_OFS_CTRL, 32'h41);
    step(1, 1'b0);
    // window mode, values loaded before enable
    for (int i = 0; i < 5; i++) begin
      v1 = (i == 0) ? 7 : $urandom % 40;
      v2 = (i == 0) ? 7 : $urandom % 40;
      wr(`CCMP_OFS_CTRL, 32'h04);
      wr(`CCMP_OFS_VAL1, v1);
      wr(`CCMP_OFS_VAL2, v2);
      wr(`CCMP_OFS_CTRL, 32'h44);
      for (int j = 0; j < 10; j++) begin
        c = (j == 0) ? v1 : $urandom % 40;
        step(c, win(c, v1, v2));
      end
    end
    wr(`CCMP_OFS_VAL1, 32'ha);
    wr(`CCMP_OFS_VAL2, 32'h3);
    step(5, 1'b1);
    wr(`CCMP_OFS_ACK, 32'h1);
    rdb(`CCMP_OFS_STAT, 3, 1'b1);
    step(20, 1'b0);
    wr(`CCMP_OFS_ACK, 32'h1);
    rdb(`CCMP_OFS_STAT, 3, 1'b0);
    wr(`CCMP_OFS_HYST, 32'h3);
    rdb(`CCMP_OFS_STAT, 5, 1'b1);
    wr(`CCMP_OFS_HYST, 32'h0);
    // down direction refuses a value below one
    wr(`CCMP_OFS_CTRL, 32'h800);
    wr(`CCMP_OFS_VAL1, 32'h0);
    rdb(`CCMP_OFS_STAT, 6, 1'b1);
    wr(`CCMP_OFS_ACK, 32'h4);
    rdb(`CCMP_OFS_STAT, 6, 1'b0);
    // pulse of two steps, from comparator and from force
    wr(`CCMP_OFS_CTRL, 32'h0);
    wr(`CCMP_OFS_PULSE, 32'h2);
    wr(`CCMP_OFS_VAL1, 32'h5);
    wr(`CCMP_OFS_CTRL, 32'h43);
    step(4, 1'b0);
    step(5, 1'b1);
    plen(n);
    check(32'(n >= 20 && n <= 21), 32'h1, "pulse length");
    wr(`CCMP_OFS_CTRL, 32'h143);
    plen(n);
    check(32'(n >= 20 && n <= 21), 32'h1, "forced pulse");
    // channel two in le mode, virtual output sampled at the strobe
    step(2, 1'b0);
    wr(`CCMP_OFS_CTRL, 32'h1090);
    rdb(`CCMP_OFS_STAT, 1, 1'b0);
    step(1, 1'b0);
    rdb(`CCMP_OFS_STAT, 1, 1'b1);
    check({31'h0, virtual_output}, 32'h0, "virtual held");
    @(posedge clk_sys);
    sample_strobe <= 1'b1;
    @(posedge clk_sys);
    sample_strobe <= 1'b0;
    #1 check({31'h0, virtual_output}, 32'h1, "virtual sampled");
    give_verdict();
  end
endmodule
`default_nettype wire
